// ---- atg_freq_loop.sv ----
// Purpose: Shared constants and types, and the frequency loop with its gain set selection.
// Assumes: One clock, synchronous active-high reset, all inputs synchronous to the clock.
// Notes: The frequency and current loop arithmetic is kept deliberately simple.
//
// Notes on behaviour
// - Selector 1 arms stationary test; enable and run start.
// - Stationary test measures, then updates current gains.
// - Selector 2 arms rotating test, stationary first.
// - Ramp to two-thirds rated frequency, hold 40 s; the hold also ends early on i_meas_done.
// - Rotating test overwrites stator inductance and breakpoints.
// - Power factor updated for display only.
// - Selector 3 arms inertia test, stores inertia.
// - Ramp to quarter rated speed, hold 60 s.
// - Speed missed on final attempt: abort, trip.
// - Any completed test enters the inhibit state.
// - No normal running until a controlled disable.
// - Disable: enable pin off, software enable, control word.
// - Current controller is PI from two gains.
// - Frequency loop: P and I forward, D on feedback.
// - Integral accumulates error, removing steady frequency error.
// - Gain select 0 uses set A, 1 set B.
// - Select 2: set A below threshold, else B.
// - Gain select accepted anytime, enabled or disabled.

package atg_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [63:0] CLK_HZ = 64'd250000000;
  localparam logic [63:0] T_ROT_HOLD_S = 64'd40;
  localparam logic [63:0] T_INR_HOLD_S = 64'd60;
  localparam logic [63:0] T_STAT_MAX_MS = 64'd5000;
  localparam logic [63:0] T_ACCEL_MAX_MS = 64'd20000;
  localparam int CNT_W = 36;
  localparam logic [1:0] INR_ATTEMPTS = 2'h3;
  // ----------------------------------------------------------------
  // Selector, gain select and trip cause codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_STAT = 2'h1;
  localparam logic [1:0] SEL_ROT = 2'h2;
  localparam logic [1:0] SEL_INR = 2'h3;
  localparam logic [1:0] GSEL_A = 2'h0;
  localparam logic [1:0] GSEL_B = 2'h1;
  localparam logic [1:0] GSEL_THR = 2'h2;
  localparam logic [1:0] TRIP_NONE = 2'h0;
  localparam logic [1:0] TRIP_STAT = 2'h1;
  localparam logic [1:0] TRIP_ROT = 2'h2;
  localparam logic [1:0] TRIP_INR = 2'h3;
  // ----------------------------------------------------------------
  // Reset values and scaling
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CUR_KP = 16'h0014;
  localparam logic [15:0] RST_CUR_KI = 16'h0028;
  localparam int GAIN_SHIFT = 8;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_STAT, ST_ROT_ACC, ST_ROT_HOLD, ST_INR_ACC, ST_INR_HOLD, ST_INHIBIT
  } atg_state_e;
  typedef struct packed {
    logic [15:0] prop;
    logic [15:0] integ;
    logic [15:0] diff;
  } atg_gain_s;
  typedef struct packed {
    logic [15:0] resistance;
    logic [15:0] trans_ind;
    logic [15:0] stator_ind;
    logic [15:0] power_factor;
    logic [15:0] inertia;
    logic [3:0][15:0] sat_bp;
  } atg_meas_s;
  typedef struct packed {
    logic [15:0] cur_kp;
    logic [15:0] cur_ki;
    logic [15:0] stator_ind;
    logic [15:0] pf_display;
    logic [15:0] inertia;
    logic [3:0][15:0] sat_bp;
  } atg_param_s;
endpackage : atg_pkg

`timescale 1ns/1ns
`default_nettype none

module atg_freq_loop (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Gain selection
  input wire logic [1:0] i_gain_sel,
  input wire logic [15:0] i_gain_thresh,
  input wire atg_pkg::atg_gain_s i_set_a,
  input wire atg_pkg::atg_gain_s i_set_b,
  // Loop signals
  input wire logic signed [15:0] i_freq_demand,
  input wire logic signed [15:0] i_freq_fb,
  output logic o_use_set_b,
  output logic signed [15:0] o_torque_ref
);
  logic [16:0] dem_abs;
  logic sel_b;
  atg_pkg::atg_gain_s g;
  logic signed [16:0] err;
  logic signed [16:0] dfb;
  logic signed [39:0] integ_ff;
  logic signed [39:0] nxt_integ;
  logic signed [39:0] sum;
  logic signed [15:0] fb_prev_ff;

  // ----------------------------------------------------------------
  // Gain set selection
  // ----------------------------------------------------------------
  assign dem_abs = i_freq_demand[15] ? 17'(-$signed({i_freq_demand[15], i_freq_demand})) :
                   {1'b0, i_freq_demand};
  always_comb begin
    case (i_gain_sel)
      atg_pkg::GSEL_A: sel_b = 1'b0;
      atg_pkg::GSEL_B: sel_b = 1'b1;
      atg_pkg::GSEL_THR: sel_b = (dem_abs >= {1'b0, i_gain_thresh});
      default: sel_b = 1'b0;
    endcase
  end
  assign g = sel_b ? i_set_b : i_set_a;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_use_set_b <= 1'b0;
    end else begin
      o_use_set_b <= sel_b;
    end
  end

  // ----------------------------------------------------------------
  // Controller terms
  // ----------------------------------------------------------------
  assign err = 17'(i_freq_demand) - 17'(i_freq_fb);
  assign dfb = 17'(i_freq_fb) - 17'(fb_prev_ff);
  assign nxt_integ = integ_ff + 40'($signed({1'b0, g.integ}) * err);
  assign sum = 40'($signed({1'b0, g.prop}) * err) + nxt_integ
             - 40'($signed({1'b0, g.diff}) * dfb);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      integ_ff <= 40'sh0;
      fb_prev_ff <= 16'sh0;
      o_torque_ref <= 16'sh0;
    end else begin
      integ_ff <= nxt_integ;
      fb_prev_ff <= i_freq_fb;
      o_torque_ref <= 16'(sum >>> atg_pkg::GAIN_SHIFT);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_gain_fixed;
    @(posedge i_mclk) disable iff (i_rst)
    (i_gain_sel == atg_pkg::GSEL_A) ##1 (i_gain_sel == atg_pkg::GSEL_B) |=> o_use_set_b;
  endproperty
  a_gain_fixed: assert property (p_gain_fixed) else $error("set B not taken after select 1");

  property p_gain_thr;
    @(posedge i_mclk) disable iff (i_rst)
    (i_gain_sel == atg_pkg::GSEL_THR) |=> (o_use_set_b == ($past(dem_abs) >= {1'b0, $past(i_gain_thresh)}));
  endproperty
  a_gain_thr: assert property (p_gain_thr) else $error("threshold gain choice wrong");

  property p_integ_hold;
    @(posedge i_mclk) disable iff (i_rst)
    (err == 17'sh0) |=> (integ_ff == $past(integ_ff));
  endproperty
  a_integ_hold: assert property (p_integ_hold) else $error("integrator moved with zero error");
endmodule : atg_freq_loop

`default_nettype wire

// ---- atg_autotune_top.sv ----
// Purpose: Autotune sequencer with current loop and frequency loop of the drive.
// Assumes: Measurement engine reports results on i_meas with a done pulse.
// Notes: Long hold times are top parameters so simulations can shorten them.

`timescale 1ns/1ns
`default_nettype none

module atg_autotune_top #(
  parameter logic [35:0] ROT_HOLD_CYC = 36'(atg_pkg::T_ROT_HOLD_S * atg_pkg::CLK_HZ),
  parameter logic [35:0] INR_HOLD_CYC = 36'(atg_pkg::T_INR_HOLD_S * atg_pkg::CLK_HZ),
  parameter logic [35:0] STAT_MAX_CYC = 36'(atg_pkg::T_STAT_MAX_MS * (atg_pkg::CLK_HZ / 64'd1000)),
  parameter logic [35:0] ACCEL_MAX_CYC = 36'(atg_pkg::T_ACCEL_MAX_MS * (atg_pkg::CLK_HZ / 64'd1000))
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Operator enable and run
  input wire logic i_hw_enable,
  input wire logic i_sw_enable,
  input wire logic i_cw_disable,
  input wire logic i_run_fwd,
  input wire logic i_run_rev,
  // Autotune selector write
  input wire logic i_sel_wr,
  input wire logic [1:0] i_sel_data,
  // Motor ratings and measurements
  input wire logic [15:0] i_rated_freq,
  input wire logic [15:0] i_rated_speed,
  input wire logic i_meas_done,
  input wire logic i_at_target,
  input wire atg_pkg::atg_meas_s i_meas,
  // Frequency loop
  input wire logic [1:0] i_gain_sel,
  input wire logic [15:0] i_gain_thresh,
  input wire atg_pkg::atg_gain_s i_set_a,
  input wire atg_pkg::atg_gain_s i_set_b,
  input wire logic signed [15:0] i_freq_demand,
  input wire logic signed [15:0] i_freq_fb,
  // Current loop
  input wire logic signed [15:0] i_cur_demand,
  input wire logic signed [15:0] i_cur_fb,
  // Sequencer status
  output logic [1:0] o_autotune_select,
  output logic o_busy,
  output logic o_trip,
  output logic [1:0] o_trip_cause,
  output logic o_inhibit,
  output logic o_run_permit,
  // Motor commands and parameters
  output logic o_motor_run,
  output logic [15:0] o_tune_ref,
  output atg_pkg::atg_param_s o_params,
  output logic o_use_set_b,
  output logic signed [15:0] o_torque_ref,
  output logic signed [15:0] o_volt_ref
);
  atg_pkg::atg_state_e state_ff;
  atg_pkg::atg_state_e nxt_state;
  logic [35:0] cnt_ff;
  logic [1:0] attempt_ff;
  logic run_ok;
  logic ctl_dis;
  logic cnt_end;
  logic acc_tmo;
  logic trip_set;
  logic [1:0] trip_code;
  logic [15:0] ref_rot;
  logic [15:0] ref_inr;
  logic signed [16:0] cerr;
  logic signed [39:0] cinteg_ff;
  logic signed [39:0] nxt_cinteg;
  logic signed [39:0] csum;
  logic [3:0][15:0] nxt_sat_bp;

  // ----------------------------------------------------------------
  // Conditions
  // ----------------------------------------------------------------
  assign run_ok = i_hw_enable & i_sw_enable & ~i_cw_disable & (i_run_fwd | i_run_rev);
  assign ctl_dis = ~i_hw_enable | ~i_sw_enable | i_cw_disable;
  assign acc_tmo = (cnt_ff >= ACCEL_MAX_CYC - 36'h1) & ~i_at_target;
  assign ref_rot = 16'(({2'h0, i_rated_freq} * 18'h2) / 18'h3);
  assign ref_inr = i_rated_speed >> 2;

  always_comb begin
    cnt_end = 1'b0;
    case (state_ff)
      atg_pkg::ST_STAT: cnt_end = (cnt_ff >= STAT_MAX_CYC - 36'h1);
      atg_pkg::ST_ROT_HOLD: cnt_end = (cnt_ff >= ROT_HOLD_CYC - 36'h1);
      atg_pkg::ST_INR_HOLD: cnt_end = (cnt_ff >= INR_HOLD_CYC - 36'h1);
      default: cnt_end = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    trip_set = 1'b0;
    trip_code = atg_pkg::TRIP_NONE;
    case (state_ff)
      atg_pkg::ST_IDLE: begin
        if (i_sel_wr && i_sel_data != atg_pkg::SEL_NONE) begin
          nxt_state = atg_pkg::ST_ARMED;
        end
      end
      atg_pkg::ST_ARMED: begin
        if (run_ok) begin
          if (o_autotune_select == atg_pkg::SEL_INR) begin
            nxt_state = atg_pkg::ST_INR_ACC;
          end else begin
            nxt_state = atg_pkg::ST_STAT;
          end
        end
      end
      atg_pkg::ST_STAT: begin
        if (i_meas_done) begin
          nxt_state = (o_autotune_select == atg_pkg::SEL_ROT) ? atg_pkg::ST_ROT_ACC : atg_pkg::ST_INHIBIT;
        end else if (cnt_end) begin
          nxt_state = atg_pkg::ST_INHIBIT;
          trip_set = 1'b1;
          trip_code = atg_pkg::TRIP_STAT;
        end
      end
      atg_pkg::ST_ROT_ACC: begin
        if (i_at_target) begin
          nxt_state = atg_pkg::ST_ROT_HOLD;
        end else if (acc_tmo) begin
          nxt_state = atg_pkg::ST_INHIBIT;
          trip_set = 1'b1;
          trip_code = atg_pkg::TRIP_ROT;
        end
      end
      atg_pkg::ST_ROT_HOLD: begin
        if (i_meas_done || cnt_end) begin
          nxt_state = atg_pkg::ST_INHIBIT;
        end
      end
      atg_pkg::ST_INR_ACC: begin
        if (i_at_target) begin
          nxt_state = atg_pkg::ST_INR_HOLD;
        end else if (acc_tmo && attempt_ff >= atg_pkg::INR_ATTEMPTS - 2'h1) begin
          nxt_state = atg_pkg::ST_INHIBIT;
          trip_set = 1'b1;
          trip_code = atg_pkg::TRIP_INR;
        end
      end
      atg_pkg::ST_INR_HOLD: begin
        if (cnt_end) begin
          nxt_state = atg_pkg::ST_INHIBIT;
        end
      end
      atg_pkg::ST_INHIBIT: begin
        if (ctl_dis) begin
          nxt_state = atg_pkg::ST_IDLE;
        end
      end
      default: nxt_state = atg_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_ff <= atg_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Phase timer and attempt counter
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_ff <= 36'h0;
      attempt_ff <= 2'h0;
    end else begin
      if (nxt_state != state_ff || (state_ff == atg_pkg::ST_INR_ACC && acc_tmo)) begin
        cnt_ff <= 36'h0;
      end else begin
        cnt_ff <= cnt_ff + 36'h1;
      end
      if (state_ff == atg_pkg::ST_ARMED) begin
        attempt_ff <= 2'h0;
      end else if (state_ff == atg_pkg::ST_INR_ACC && acc_tmo) begin
        attempt_ff <= attempt_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Selector, status and trip
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_autotune_select <= atg_pkg::SEL_NONE;
    end else if (nxt_state == atg_pkg::ST_INHIBIT || nxt_state == atg_pkg::ST_IDLE) begin
      o_autotune_select <= atg_pkg::SEL_NONE;
    end else if (state_ff == atg_pkg::ST_IDLE && i_sel_wr) begin
      o_autotune_select <= i_sel_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      o_inhibit <= 1'b0;
      o_run_permit <= 1'b1;
      o_motor_run <= 1'b0;
      o_tune_ref <= 16'h0;
    end else begin
      o_busy <= (nxt_state != atg_pkg::ST_IDLE) && (nxt_state != atg_pkg::ST_INHIBIT);
      o_inhibit <= (nxt_state == atg_pkg::ST_INHIBIT);
      o_run_permit <= (nxt_state == atg_pkg::ST_IDLE);
      o_motor_run <= (nxt_state == atg_pkg::ST_ROT_ACC) || (nxt_state == atg_pkg::ST_ROT_HOLD) ||
                     (nxt_state == atg_pkg::ST_INR_ACC) || (nxt_state == atg_pkg::ST_INR_HOLD);
      if (nxt_state == atg_pkg::ST_ROT_ACC || nxt_state == atg_pkg::ST_ROT_HOLD) begin
        o_tune_ref <= ref_rot;
      end else if (nxt_state == atg_pkg::ST_INR_ACC || nxt_state == atg_pkg::ST_INR_HOLD) begin
        o_tune_ref <= ref_inr;
      end else begin
        o_tune_ref <= 16'h0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_trip <= 1'b0;
      o_trip_cause <= atg_pkg::TRIP_NONE;
    end else if (trip_set) begin
      o_trip <= 1'b1;
      o_trip_cause <= trip_code;
    end else if (state_ff == atg_pkg::ST_ARMED) begin
      o_trip <= 1'b0;
      o_trip_cause <= atg_pkg::TRIP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Parameter updates from measurements
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_params.cur_kp <= atg_pkg::RST_CUR_KP;
      o_params.cur_ki <= atg_pkg::RST_CUR_KI;
      o_params.stator_ind <= 16'h0;
      o_params.pf_display <= 16'h0;
      o_params.inertia <= 16'h0;
      o_params.sat_bp <= 64'h0;
    end else begin
      if (state_ff == atg_pkg::ST_STAT && i_meas_done) begin
        o_params.cur_kp <= i_meas.trans_ind;
        o_params.cur_ki <= i_meas.resistance;
      end
      if (state_ff == atg_pkg::ST_ROT_HOLD && nxt_state == atg_pkg::ST_INHIBIT) begin
        o_params.stator_ind <= i_meas.stator_ind;
        o_params.pf_display <= i_meas.power_factor;
      end
      if (state_ff == atg_pkg::ST_INR_HOLD && cnt_end) begin
        o_params.inertia <= i_meas.inertia;
      end
      o_params.sat_bp <= nxt_sat_bp;
    end
  end

  genvar bp;
  generate
    for (bp = 0; bp < 4; bp++) begin : g_sat_bp
      assign nxt_sat_bp[bp] = (state_ff == atg_pkg::ST_ROT_HOLD && nxt_state == atg_pkg::ST_INHIBIT) ?
                              i_meas.sat_bp[bp] : o_params.sat_bp[bp];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Current loop and frequency loop
  // ----------------------------------------------------------------
  assign cerr = 17'(i_cur_demand) - 17'(i_cur_fb);
  assign nxt_cinteg = cinteg_ff + 40'($signed({1'b0, o_params.cur_ki}) * cerr);
  assign csum = 40'($signed({1'b0, o_params.cur_kp}) * cerr) + nxt_cinteg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cinteg_ff <= 40'sh0;
      o_volt_ref <= 16'sh0;
    end else begin
      cinteg_ff <= nxt_cinteg;
      o_volt_ref <= 16'(csum >>> atg_pkg::GAIN_SHIFT);
    end
  end

  atg_freq_loop u_freq_loop (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_gain_sel(i_gain_sel),
    .i_gain_thresh(i_gain_thresh),
    .i_set_a(i_set_a),
    .i_set_b(i_set_b),
    .i_freq_demand(i_freq_demand),
    .i_freq_fb(i_freq_fb),
    .o_use_set_b(o_use_set_b),
    .o_torque_ref(o_torque_ref)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_arm_wait;
    @(posedge i_mclk) disable iff (i_rst)
    (state_ff == atg_pkg::ST_ARMED && !run_ok) |=> (state_ff == atg_pkg::ST_ARMED) && !o_motor_run;
  endproperty
  a_arm_wait: assert property (p_arm_wait) else $error("test started without enable and run");

  property p_stat_gains;
    @(posedge i_mclk) disable iff (i_rst)
    (state_ff == atg_pkg::ST_STAT && i_meas_done) |=>
      (o_params.cur_kp == $past(i_meas.trans_ind)) && (o_params.cur_ki == $past(i_meas.resistance));
  endproperty
  a_stat_gains: assert property (p_stat_gains) else $error("current gains not updated");

  sequence s_stat_done;
    (state_ff == atg_pkg::ST_STAT) && i_meas_done && (o_autotune_select == atg_pkg::SEL_ROT);
  endsequence
  sequence s_rot_ramp;
    (state_ff == atg_pkg::ST_ROT_ACC) && o_motor_run && (o_tune_ref == $past(ref_rot));
  endsequence
  property p_rot_chain;
    @(posedge i_mclk) disable iff (i_rst)
    s_stat_done |=> s_rot_ramp;
  endproperty
  a_rot_chain: assert property (p_rot_chain) else $error("rotating phase did not follow stationary");

  property p_rot_hold_max;
    @(posedge i_mclk) disable iff (i_rst)
    (state_ff == atg_pkg::ST_ROT_HOLD && cnt_ff == ROT_HOLD_CYC - 36'h1) |=> o_inhibit && !o_motor_run;
  endproperty
  a_rot_hold_max: assert property (p_rot_hold_max) else $error("rotating hold overran");

  property p_inr_trip;
    @(posedge i_mclk) disable iff (i_rst)
    (state_ff == atg_pkg::ST_INR_ACC && acc_tmo && attempt_ff == atg_pkg::INR_ATTEMPTS - 2'h1) |=>
      o_trip && (o_trip_cause == atg_pkg::TRIP_INR) && o_inhibit;
  endproperty
  a_inr_trip: assert property (p_inr_trip) else $error("inertia failure did not trip");

  property p_done_inhibit;
    @(posedge i_mclk) disable iff (i_rst)
    $fell(o_busy) |-> o_inhibit && !o_run_permit;
  endproperty
  a_done_inhibit: assert property (p_done_inhibit) else $error("end of test without inhibit");

  property p_disable_release;
    @(posedge i_mclk) disable iff (i_rst)
    (o_inhibit && state_ff == atg_pkg::ST_INHIBIT) |=>
      ($past(ctl_dis) ? (o_run_permit && !o_inhibit) : (o_inhibit && !o_run_permit));
  endproperty
  a_disable_release: assert property (p_disable_release) else $error("inhibit exit wrong");

  property p_sel_clear;
    @(posedge i_mclk) disable iff (i_rst)
    $fell(o_busy) |-> (o_autotune_select == atg_pkg::SEL_NONE);
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("selector not cleared");
endmodule : atg_autotune_top

`default_nettype wire

// ---- atg_motor_model.sv ----
// Purpose: Behavioural motor and measurement engine for the autotune top.
// Assumes: Runs on the drive clock.
// Notes: Reaches target after a short spin-up unless told to stall.
`timescale 1ns/1ns
`default_nettype none
module atg_motor_model (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Drive status and stall control
  input wire logic i_busy,
  input wire logic i_motor_run,
  input wire logic i_stall,
  // Motor feedback
  output logic o_at_target,
  output logic o_meas_done
);
  logic [7:0] cnt_ff;
  logic run_q_ff;
  always_ff @(posedge i_mclk) begin
    run_q_ff <= i_motor_run;
    if (i_rst || !i_busy || run_q_ff != i_motor_run) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hFF) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  assign o_at_target = i_motor_run && !i_stall && cnt_ff >= 8'h08;
  assign o_meas_done = i_busy && (i_motor_run ? cnt_ff == 8'h14 : cnt_ff == 8'h0A);
endmodule : atg_motor_model
`default_nettype wire

// ---- tb.sv ----
// Purpose: Self-checking bench for the autotune top.
// Assumes: Short hold and timeout parameters.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic hw_en, sw_en, cw_dis, run_fwd, run_rev, sel_wr, stall, at_tgt, m_done;
  logic busy, trip, inhibit, permit, m_run, use_b;
  logic [1:0] sel_data, gain_sel, sel_q, cause;
  logic [15:0] r_freq, r_speed, thr, tune_ref;
  logic signed [15:0] f_dem, f_fb, c_dem, c_fb, tq, vref;
  logic [159:0] rnd;
  atg_pkg::atg_meas_s meas;
  atg_pkg::atg_gain_s set_a, set_b;
  atg_pkg::atg_param_s prm;
  integer seed = 32'h7AC7;
  int mismatches = 0;
  int compares = 0;
  always #2 i_mclk = ~i_mclk;
  atg_autotune_top #(.ROT_HOLD_CYC(36'h0A), .INR_HOLD_CYC(36'h32), .STAT_MAX_CYC(36'h64),
    .ACCEL_MAX_CYC(36'h28)) dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_hw_enable(hw_en),
    .i_sw_enable(sw_en), .i_cw_disable(cw_dis), .i_run_fwd(run_fwd), .i_run_rev(run_rev),
    .i_sel_wr(sel_wr), .i_sel_data(sel_data), .i_rated_freq(r_freq), .i_rated_speed(r_speed),
    .i_meas_done(m_done), .i_at_target(at_tgt), .i_meas(meas), .i_gain_sel(gain_sel),
    .i_gain_thresh(thr), .i_set_a(set_a), .i_set_b(set_b), .i_freq_demand(f_dem), .i_freq_fb(f_fb),
    .i_cur_demand(c_dem), .i_cur_fb(c_fb), .o_autotune_select(sel_q), .o_busy(busy), .o_trip(trip),
    .o_trip_cause(cause), .o_inhibit(inhibit), .o_run_permit(permit), .o_motor_run(m_run),
    .o_tune_ref(tune_ref), .o_params(prm), .o_use_set_b(use_b), .o_torque_ref(tq), .o_volt_ref(vref));
  atg_motor_model motor (.i_mclk(i_mclk), .i_rst(i_rst), .i_busy(busy), .i_motor_run(m_run),
    .i_stall(stall), .o_at_target(at_tgt), .o_meas_done(m_done));
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("Counts: %0d mismatches in %0d compares", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic gain_case(input logic [1:0] gs, input logic eq);
    int mag;
    @(negedge i_mclk);
    gain_sel = gs;
    f_dem = 16'($random(seed));
    mag = (f_dem < 0) ? -int'(f_dem) : int'(f_dem);
    thr = eq ? 16'(mag) : 16'($random(seed));
    f_fb = 16'($random(seed));
    c_dem = 16'($random(seed));
    hw_en = 1'($random(seed));
    repeat (2) @(negedge i_mclk);
    chk(use_b, (gs == atg_pkg::GSEL_B) || (gs == atg_pkg::GSEL_THR && mag >= int'(thr)));
  endtask : gain_case
  task automatic run_test(input logic [1:0] sel, input int dis, input logic stl);
    @(negedge i_mclk);
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    meas = rnd[143:0];
    stall = stl;
    sel_wr = 1'b1;
    sel_data = sel;
    hw_en = 1'b1;
    sw_en = 1'b1;
    cw_dis = 1'b0;
    @(negedge i_mclk);
    sel_wr = 1'b0;
    @(negedge i_mclk);
    chk({sel_q, busy, m_run}, {sel, 2'h2});
    run_fwd = ~sel[0];
    run_rev = sel[0];
    if (sel != atg_pkg::SEL_STAT) begin
      for (int i = 0; i < 400 && !m_run; i++) @(negedge i_mclk);
      chk(tune_ref, sel == atg_pkg::SEL_ROT ? 16'((32'(r_freq) * 2) / 3) : r_speed >> 2);
    end
    for (int i = 0; i < 1000 && !inhibit; i++) @(negedge i_mclk);
    chk({inhibit, sel_q, busy, permit}, 5'h10);
    chk({trip, cause}, stl ? {1'b1, ((sel == atg_pkg::SEL_ROT) ? atg_pkg::TRIP_ROT : atg_pkg::TRIP_INR)} :
      3'h0);
    if (sel != atg_pkg::SEL_INR) chk({prm.cur_kp, prm.cur_ki}, {meas.trans_ind, meas.resistance});
    if (sel == atg_pkg::SEL_STAT) chk(prm.pf_display, 16'h0);
    if (sel == atg_pkg::SEL_ROT && !stl)
      chk({prm.stator_ind, prm.pf_display, prm.sat_bp}, {meas.stator_ind, meas.power_factor, meas.sat_bp});
    if (sel == atg_pkg::SEL_INR && !stl) chk(prm.inertia, meas.inertia);
    sel_wr = 1'b1;
    sel_data = atg_pkg::SEL_STAT;
    @(negedge i_mclk);
    sel_wr = 1'b0;
    repeat (2) @(negedge i_mclk);
    chk({sel_q, busy, inhibit}, 4'h1);
    case (dis)
      0: hw_en = 1'b0;
      1: sw_en = 1'b0;
      default: cw_dis = 1'b1;
    endcase
    repeat (2) @(negedge i_mclk);
    chk({inhibit, permit}, 2'h1);
    hw_en = 1'b1;
    sw_en = 1'b1;
    cw_dis = 1'b0;
    run_fwd = 1'b0;
    run_rev = 1'b0;
  endtask : run_test
  initial begin
    {hw_en, sw_en, cw_dis, run_fwd, run_rev, sel_wr, stall, sel_data, gain_sel} = 11'h0;
    {thr, f_dem, f_fb, c_dem, c_fb} = 80'h0;
    meas = '0;
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    {set_a, set_b} = rnd[95:0];
    r_freq = rnd[111:96];
    r_speed = rnd[127:112];
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    @(negedge i_mclk);
    chk({permit, prm.cur_kp, prm.cur_ki, busy, inhibit, sel_q},
      {1'b1, atg_pkg::RST_CUR_KP, atg_pkg::RST_CUR_KI, 4'h0});
    chk({tq, vref}, 32'h0);
    f_dem = 16'sh0100;
    c_dem = 16'sh0100;
    @(negedge i_mclk);
    chk({tq, vref}, {16'(set_a.prop + set_a.integ), 16'(atg_pkg::RST_CUR_KP + atg_pkg::RST_CUR_KI)});
    f_dem = 16'sh0;
    c_dem = 16'sh0;
    @(negedge i_mclk);
    chk({tq, vref}, {set_a.integ, atg_pkg::RST_CUR_KI});
    for (int i = 0; i < 24; i++) gain_case(2'(i % 4), i % 8 == 2);
    run_test(atg_pkg::SEL_STAT, 0, 1'b0);
    run_test(atg_pkg::SEL_ROT, 1, 1'b0);
    run_test(atg_pkg::SEL_INR, 2, 1'b0);
    run_test(atg_pkg::SEL_INR, 0, 1'b1);
    run_test(atg_pkg::SEL_ROT, 2, 1'b1);
    end_sim();
  end
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
